// ### interrupt_msg_cap_header_pkg.sv
// interrupt_msg_cap_header_pkg: offsets, field positions, reset values and states for the
// interrupt message and subsystem ident capability register bank.
// assumes a 32-bit classic wishbone slave with byte addresses.
package interrupt_msg_cap_header_pkg;

    // register byte offsets
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_CAP_HDR   = 12'h0D0;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_LOW  = 12'h0D4;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_HIGH = 12'h0D8;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_PAYLOAD   = 12'h0DC;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_SS_HDR    = 12'h0F0;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_SS_CODES  = 12'h0F4;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_LOCK      = 12'h0E0;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_EVT_STAT  = 12'h0E4;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_EVT_CLR   = 12'h0E8;
    localparam logic [11:0] INTERRUPT_MSG_CAP_HEADER_OFS_EVT_EN    = 12'h0EC;

    // fixed field values
    localparam logic [7:0]  INTERRUPT_MSG_CAP_HEADER_CAPABILITY_IDENTIFIER_MSG     = 8'h05;
    localparam logic [7:0]  INTERRUPT_MSG_CAP_HEADER_CAPABILITY_IDENTIFIER_SS      = 8'h0D;
    localparam logic [7:0]  INTERRUPT_MSG_CAP_HEADER_NXT_RST       = 8'h00;
    localparam logic [2:0]  INTERRUPT_MSG_CAP_HEADER_REQ_CNT       = 3'h0;
    localparam logic [2:0]  INTERRUPT_MSG_CAP_HEADER_GRANT_RST     = 3'h0;
    localparam logic        INTERRUPT_MSG_CAP_HEADER_WIDE_CAPABLE  = 1'b1;
    localparam logic [31:0] INTERRUPT_MSG_CAP_HEADER_WORD_RST      = 32'h0000_0000;

    // header field positions
    localparam int          INTERRUPT_MSG_CAP_HEADER_NXT_LSB       = 8;
    localparam int          INTERRUPT_MSG_CAP_HEADER_EN_BIT        = 16;
    localparam int          INTERRUPT_MSG_CAP_HEADER_GRANT_LSB     = 20;

    // event bits
    localparam int          INTERRUPT_MSG_CAP_HEADER_EVT_SENT      = 0;
    localparam int          INTERRUPT_MSG_CAP_HEADER_EVT_DROP      = 1;
    localparam int          INTERRUPT_MSG_CAP_HEADER_EVT_W         = 2;

    // transmit sequencer states
    typedef enum logic [1:0] {
        INTERRUPT_MSG_CAP_HEADER_TX_IDLE,
        INTERRUPT_MSG_CAP_HEADER_TX_SEND
    } interrupt_msg_cap_header_tx_type;

endpackage

// ### interrupt_msg_cap_header_wb_slave.sv
// interrupt_msg_cap_header_wb_slave: classic wishbone handshake, one access per request.
// assumes master holds the request until ack; ack lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module interrupt_msg_cap_header_wb_slave (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // bus request
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    // access strobe and ack
    output logic             acc_o,
    output logic             wb_ack_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic ack;   // ack flop
    } interrupt_msg_cap_header_wbs_type;

    interrupt_msg_cap_header_wbs_type st_r;
    interrupt_msg_cap_header_wbs_type st_nxt;

    // ack one cycle after request, then drop
    always_comb begin
        st_nxt     = st_r;
        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
    end

    // register the state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign acc_o    = st_nxt.ack;
    assign wb_ack_o = st_r.ack;
endmodule
`default_nettype wire

// ### interrupt_msg_cap_header_regs.sv
// interrupt_msg_cap_header_regs: interrupt message capability and subsystem ident registers
// of one switch port, plus the memory write request that signals one.
// assumes the port's transaction layer takes the request over valid/ready.
// assumes software keeps the message address routed toward upstream.
// assumes one clock; every input comes from logic on clk_sys.
// assumes the granted count never changes behaviour: one message only.
//
// Summary of operation
// - message capability id reads 0x05
// - message next pointer defaults zero
// - enable bit read-write, resets zero
// - requested count zero; granted count resets zero
// - wide address capable bit reads one
// - low address dword aligned, bits 1:0 zero
// - interrupt writes always leave upstream port
// - nonzero high address gives 64-bit write
// - zero high address gives 32-bit write
// - payload low sixteen bits, upper zero
// - subsystem capability id reads 0x0D
// - subsystem next pointer defaults zero, upper reserved
// - card vendor and product codes lockable
`timescale 1ns/1ps
`default_nettype none
module interrupt_msg_cap_header_regs
    import interrupt_msg_cap_header_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // interrupt request from port logic
    input  wire logic        msg_req,
    // memory write request to upstream port
    output logic             mwr_valid,
    input  wire logic        mwr_ready,
    output logic      [63:0] mwr_addr,
    output logic             mwr_wide,
    output logic      [31:0] mwr_data,
    output logic             mwr_upstream,
    // event interrupt
    output logic             irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        // message capability fields
        logic                  enable;      // message enable
        logic [2:0]            granted_msg_count; // storage only
        logic [7:0]            msg_next_ptr; // lockable link
        // message address and payload
        logic [29:0]           addr_low;    // address bits 31:2
        logic [31:0]           addr_high;   // zero means narrow write
        logic [15:0]           payload_low_half; // low payload half
        // subsystem ident fields
        logic [7:0]            ss_next_ptr; // lockable link
        logic [15:0]           card_vendor_code;  // lockable
        logic [15:0]           card_product_code; // lockable
        logic                  lock;        // write lock for lockable fields
        // event status and enable
        logic [INTERRUPT_MSG_CAP_HEADER_EVT_W-1:0] evt_stat;  // sticky status
        logic [INTERRUPT_MSG_CAP_HEADER_EVT_W-1:0] evt_en;    // per event enable
        // transmit side
        logic                  pending;     // request seen, not yet sent
        interrupt_msg_cap_header_tx_type         tx;          // sequencer state
        logic                  mwr_valid;   // request to upstream
        logic [63:0]           mwr_addr;    // snapshot at launch
        logic                  mwr_wide;    // snapshot at launch
        logic [31:0]           mwr_data;    // snapshot at launch
        // bus side
        logic [31:0]           rdata;       // read data, ack cycle only
        logic                  irq;         // event interrupt flop
    } interrupt_msg_cap_header_st_type;

    interrupt_msg_cap_header_st_type st_r;
    interrupt_msg_cap_header_st_type st_nxt;

    // ----------------------------------------
    // per-cycle strobes
    // ----------------------------------------
    logic          acc;       // read taken this cycle
    logic          wr;        // write lands this cycle
    logic [31:0]   bmask;     // byte lane mask
    logic [31:0]   rd_word;   // read mux
    logic [INTERRUPT_MSG_CAP_HEADER_EVT_W-1:0] evt_set; // events raised this cycle
    logic [INTERRUPT_MSG_CAP_HEADER_EVT_W-1:0] evt_clr; // clears written this cycle

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    // ack one cycle after the request is first seen
    interrupt_msg_cap_header_wb_slave u_wbs (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .acc_o    (acc),
        .wb_ack_o (wb_ack_o)
    );

    // a write lands at the edge where the master samples ack high,
    // while address, lanes and data still stand; reads are taken one
    // edge earlier so the registered data stands in the ack cycle
    assign wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;

    // byte lane mask from sel
    // one lane of eight bits per sel bit
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign bmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    // merge write data into an old word
    // bytes with sel low keep their old value
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] msk,
                                          input logic [31:0] new_v);
        merge = (old_v & ~msk) | (new_v & msk);
    endfunction

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rd_word = INTERRUPT_MSG_CAP_HEADER_WORD_RST;
        case (wb_adr_i)
            // fixed header fields
            // read-only values come from the package
            INTERRUPT_MSG_CAP_HEADER_OFS_CAP_HDR: begin
                rd_word = {8'h00, INTERRUPT_MSG_CAP_HEADER_WIDE_CAPABLE, st_r.granted_msg_count, INTERRUPT_MSG_CAP_HEADER_REQ_CNT,
                           st_r.enable, st_r.msg_next_ptr, INTERRUPT_MSG_CAP_HEADER_CAPABILITY_IDENTIFIER_MSG};
            end
            INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_LOW:  rd_word = {st_r.addr_low, 2'b00};
            // full high address word
            INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_HIGH: rd_word = st_r.addr_high;
            INTERRUPT_MSG_CAP_HEADER_OFS_PAYLOAD:   rd_word = {16'h0000, st_r.payload_low_half};
            INTERRUPT_MSG_CAP_HEADER_OFS_SS_HDR:    rd_word = {16'h0000, st_r.ss_next_ptr, INTERRUPT_MSG_CAP_HEADER_CAPABILITY_IDENTIFIER_SS};
            // product code high, vendor code low
            INTERRUPT_MSG_CAP_HEADER_OFS_SS_CODES:  rd_word = {st_r.card_product_code, st_r.card_vendor_code};
            // lock flag in bit 0
            INTERRUPT_MSG_CAP_HEADER_OFS_LOCK:      rd_word = {31'h0, st_r.lock};
            // sticky status and its enables
            INTERRUPT_MSG_CAP_HEADER_OFS_EVT_STAT:  rd_word = {30'h0, st_r.evt_stat};
            INTERRUPT_MSG_CAP_HEADER_OFS_EVT_EN:    rd_word = {30'h0, st_r.evt_en};
            default:              rd_word = INTERRUPT_MSG_CAP_HEADER_WORD_RST; // unmapped reads zero
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [31:0] w;
        w       = INTERRUPT_MSG_CAP_HEADER_WORD_RST;
        st_nxt  = st_r;
        evt_set = '0;
        evt_clr = '0;

        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (wr) begin
            case (wb_adr_i)
                INTERRUPT_MSG_CAP_HEADER_OFS_CAP_HDR: begin
                    // old word with fixed fields zeroed, lanes merged in
                    w = merge({8'h00, 1'b0, st_r.granted_msg_count, 3'h0, st_r.enable,
                               st_r.msg_next_ptr, 8'h00}, bmask, wb_dat_i);
                    st_nxt.enable            = w[INTERRUPT_MSG_CAP_HEADER_EN_BIT];
                    // granted count storage, never changes behaviour
                    st_nxt.granted_msg_count = w[INTERRUPT_MSG_CAP_HEADER_GRANT_LSB +: 3];
                    if (!st_r.lock) begin
                        // unlocked: software may relink the list
                        st_nxt.msg_next_ptr = w[INTERRUPT_MSG_CAP_HEADER_NXT_LSB +: 8];
                    end
                end
                INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_LOW: begin
                    w = merge({st_r.addr_low, 2'b00}, bmask, wb_dat_i);
                    st_nxt.addr_low = w[31:2];
                end
                INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_HIGH: begin
                    // every bit writable
                    st_nxt.addr_high = merge(st_r.addr_high, bmask, wb_dat_i);
                end
                INTERRUPT_MSG_CAP_HEADER_OFS_PAYLOAD: begin
                    w = merge({16'h0000, st_r.payload_low_half}, bmask, wb_dat_i);
                    st_nxt.payload_low_half = w[15:0];
                end
                INTERRUPT_MSG_CAP_HEADER_OFS_SS_HDR: begin
                    w = merge({16'h0000, st_r.ss_next_ptr, 8'h00}, bmask, wb_dat_i);
                    if (!st_r.lock) begin
                        st_nxt.ss_next_ptr = w[INTERRUPT_MSG_CAP_HEADER_NXT_LSB +: 8];
                    end
                end
                INTERRUPT_MSG_CAP_HEADER_OFS_SS_CODES: begin
                    w = merge({st_r.card_product_code, st_r.card_vendor_code}, bmask, wb_dat_i);
                    if (!st_r.lock) begin
                        st_nxt.card_vendor_code  = w[15:0];
                        st_nxt.card_product_code = w[31:16];
                    end
                end
                INTERRUPT_MSG_CAP_HEADER_OFS_LOCK: begin
                    // bit 0 locks next pointers and codes
                    if (wb_sel_i[0]) begin
                        st_nxt.lock = wb_dat_i[0];
                    end
                end
                INTERRUPT_MSG_CAP_HEADER_OFS_EVT_CLR: begin
                    // write one to clear, reads back zero
                    if (wb_sel_i[0]) begin
                        evt_clr = wb_dat_i[INTERRUPT_MSG_CAP_HEADER_EVT_W-1:0];
                    end
                end
                INTERRUPT_MSG_CAP_HEADER_OFS_EVT_EN: begin
                    // events allowed to raise irq
                    if (wb_sel_i[0]) begin
                        st_nxt.evt_en = wb_dat_i[INTERRUPT_MSG_CAP_HEADER_EVT_W-1:0];
                    end
                end
                default: begin
                    // unmapped writes dropped
                    // the access is still acked
                end
            endcase
        end

        // ----------------------------------------
        // interrupt request capture
        // ----------------------------------------
        if (msg_req) begin
            if (st_r.enable) begin
                // coalesces with a request already pending
                st_nxt.pending = 1'b1;
            end else begin
                // disabled: only log the drop
                evt_set[INTERRUPT_MSG_CAP_HEADER_EVT_DROP] = 1'b1;
            end
        end

        // ----------------------------------------
        // transmit sequencer
        // ----------------------------------------
        case (st_r.tx)
            INTERRUPT_MSG_CAP_HEADER_TX_IDLE: begin
                if (st_r.pending && st_r.enable) begin
                    // a request in the launch cycle stays pending
                    st_nxt.pending   = msg_req;
                    st_nxt.mwr_valid = 1'b1;
                    st_nxt.mwr_wide  = (st_r.addr_high != 32'h0000_0000);
                    st_nxt.mwr_addr  = {st_r.addr_high, st_r.addr_low, 2'b00};
                    st_nxt.mwr_data  = {16'h0000, st_r.payload_low_half};
                    st_nxt.tx        = INTERRUPT_MSG_CAP_HEADER_TX_SEND;
                end
            end
            INTERRUPT_MSG_CAP_HEADER_TX_SEND: begin
                // hold until accepted
                if (mwr_ready) begin
                    // taken: drop valid and log the send
                    st_nxt.mwr_valid = 1'b0;
                    st_nxt.tx        = INTERRUPT_MSG_CAP_HEADER_TX_IDLE;
                    evt_set[INTERRUPT_MSG_CAP_HEADER_EVT_SENT] = 1'b1;
                end
            end
            default: begin
                // stray encoding: back to idle, nothing sent
                st_nxt.mwr_valid = 1'b0;
                st_nxt.tx        = INTERRUPT_MSG_CAP_HEADER_TX_IDLE;
            end
        endcase

        // ----------------------------------------
        // sticky events, set wins over clear
        // ----------------------------------------
        // an event in the clear cycle is kept, never lost
        // irq from the next state, so it lags status by nothing
        st_nxt.evt_stat = (st_r.evt_stat & ~evt_clr) | evt_set;
        st_nxt.irq      = |(st_nxt.evt_stat & st_nxt.evt_en);

        // read data for the ack cycle
        st_nxt.rdata = (acc && !wb_we_i) ? rd_word : INTERRUPT_MSG_CAP_HEADER_WORD_RST;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // async reset to the documented defaults, sequencer idle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r                   <= '0;
            st_r.granted_msg_count <= INTERRUPT_MSG_CAP_HEADER_GRANT_RST;
            st_r.msg_next_ptr      <= INTERRUPT_MSG_CAP_HEADER_NXT_RST;
            st_r.ss_next_ptr       <= INTERRUPT_MSG_CAP_HEADER_NXT_RST;
            st_r.tx                <= INTERRUPT_MSG_CAP_HEADER_TX_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // every output is a plain state flop
    assign wb_dat_o     = st_r.rdata;
    assign mwr_valid    = st_r.mwr_valid;
    assign mwr_addr     = st_r.mwr_addr;
    assign mwr_wide     = st_r.mwr_wide;
    assign mwr_data     = st_r.mwr_data;
    assign mwr_upstream = st_r.mwr_valid;
    assign irq          = st_r.irq;
endmodule
`default_nettype wire

// ### interrupt_msg_cap_header_regs_props.sv
// interrupt_msg_cap_header_regs_props: port checker for the capability register bank.
// assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module interrupt_msg_cap_header_regs_props (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // wishbone side
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // memory write side
    input wire logic        mwr_valid,
    input wire logic        mwr_ready,
    input wire logic [63:0] mwr_addr,
    input wire logic        mwr_wide,
    input wire logic [31:0] mwr_data,
    input wire logic        mwr_upstream
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    mwr_hold_a: assert property (mwr_valid && !mwr_ready |=> mwr_valid && $stable(mwr_addr) && $stable(mwr_data))
        else $error("write request changed before acceptance");
    mwr_drop_a: assert property (mwr_valid && mwr_ready |=> !mwr_valid)
        else $error("write request not dropped after acceptance");
    route_up_a: assert property (mwr_upstream == mwr_valid)
        else $error("write not routed upstream");
    data_upper_a: assert property (mwr_valid |-> mwr_data[31:16] == 16'h0000)
        else $error("payload upper half not zero");
    addr_align_a: assert property (mwr_valid |-> mwr_addr[1:0] == 2'h0)
        else $error("write address not dword aligned");
    wide_sel_a: assert property (mwr_valid |-> mwr_wide == (mwr_addr[63:32] != 32'h0000_0000))
        else $error("wide flag disagrees with high address");
endmodule
`default_nettype wire

// ### interrupt_msg_cap_header_upstream_model.sv
// interrupt_msg_cap_header_upstream_model: upstream transaction logic taking memory writes.
// assumes valid is held until ready; stall sets the wait before ready.
`timescale 1ns/1ps
`default_nettype none
module interrupt_msg_cap_header_upstream_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // request from the register bank
    input  wire logic        mwr_valid,
    output logic             mwr_ready,
    input  wire logic [63:0] mwr_addr,
    input  wire logic        mwr_wide,
    input  wire logic [31:0] mwr_data,
    // bench control and record
    input  wire logic [3:0]  stall,
    output logic      [63:0] got_addr,
    output logic             got_wide,
    output logic      [31:0] got_data,
    output logic      [7:0]  got_cnt
);
    logic [3:0] wait_r; // cycles the request has waited
    // accept upstream writes: ready after stall, capture on acceptance
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mwr_ready <= 1'b0;
            wait_r    <= 4'h0;
            got_cnt   <= 8'h00;
            got_addr  <= 64'h0;
            got_wide  <= 1'b0;
            got_data  <= 32'h0;
        end else begin
            wait_r    <= (mwr_valid && !mwr_ready) ? wait_r + 4'h1 : 4'h0;
            mwr_ready <= mwr_valid && !mwr_ready && wait_r >= stall;
            if (mwr_valid && mwr_ready) begin
                got_cnt  <= got_cnt + 8'h01;
                got_addr <= mwr_addr;
                got_wide <= mwr_wide;
                got_data <= mwr_data;
            end
        end
    end
endmodule
`default_nettype wire

// ### test_msi_and_subsystem_capability_regs.sv
// test_msi_and_subsystem_capability_regs: self-checking bench of the bank.
// assumes interrupt_msg_cap_header_pkg, interrupt_msg_cap_header_regs and the upstream model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_msi_and_subsystem_capability_regs;
    import interrupt_msg_cap_header_pkg::*;
    logic        clk_sys, rst_b, wb_cyc, wb_stb, wb_we, msg_req, mwr_valid, mwr_ready;
    logic        mwr_wide, mwr_upstream, irq, wb_ack, got_wide;
    logic [11:0] wb_adr;
    logic [31:0] wb_wdat, wb_rdat, mwr_data, got_data, q;
    logic [63:0] mwr_addr, got_addr;
    logic [7:0]  got_cnt;
    logic [3:0]  stall, wb_sel, lanes;
    int          errors, n_compared;
    interrupt_msg_cap_header_regs u_interrupt_msg_cap_header_regs (.clk_sys, .rst_b, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .msg_req, .mwr_valid, .mwr_ready, .mwr_addr, .mwr_wide, .mwr_data, .mwr_upstream, .irq);
    interrupt_msg_cap_header_upstream_model u_interrupt_msg_cap_header_upstream_model (.clk_sys, .rst_b, .mwr_valid, .mwr_ready, .mwr_addr,
        .mwr_wide, .mwr_data, .stall, .got_addr, .got_wide, .got_data, .got_cnt);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // compare seen against expected, count both
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one classic wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        wb_sel <= lanes;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        chk("wb ack", {63'h0, wb_ack}, 64'h1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk($sformatf("reg %0h", a), {32'h0, q}, {32'h0, exp});
    endtask
    // one interrupt request, waits for the model to take it
    task automatic send(input logic [3:0] st);
        int n;
        logic [7:0] c0;
        stall <= st;
        c0 = got_cnt;
        @(posedge clk_sys) msg_req <= 1'b1;
        @(posedge clk_sys) msg_req <= 1'b0;
        n = 0;
        while (got_cnt === c0 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t_reset;
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_CAP_HDR, 32'h0080_0005);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_LOW, 32'h0);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_HIGH, 32'h0);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_PAYLOAD, 32'h0);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_SS_HDR, 32'h0000_000D);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_SS_CODES, 32'h0);
        chk("irq reset", irq, 1'b0);
    endtask
    task automatic t_ones;
        logic [11:0] ofs[7] = '{INTERRUPT_MSG_CAP_HEADER_OFS_CAP_HDR, INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_LOW, INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_HIGH,
            INTERRUPT_MSG_CAP_HEADER_OFS_PAYLOAD, INTERRUPT_MSG_CAP_HEADER_OFS_SS_HDR, INTERRUPT_MSG_CAP_HEADER_OFS_SS_CODES, 12'h0C0};
        logic [31:0] exp[7] = '{32'h00F1_FF05, 32'hFFFF_FFFC, 32'hFFFF_FFFF, 32'h0000_FFFF,
            32'h0000_FF0D, 32'hFFFF_FFFF, 32'h0};
        foreach (ofs[i]) wb(1'b1, ofs[i], 32'hFFFF_FFFF);
        foreach (ofs[i]) rd(ofs[i], exp[i]);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_LOCK, 32'h1);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_SS_CODES, 32'h0);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_SS_CODES, 32'hFFFF_FFFF);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_LOCK, 32'h1);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_SS_HDR, 32'h0);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_SS_HDR, 32'h0000_FF0D);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_LOCK, 32'h0);
        lanes = 4'h1;
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_PAYLOAD, 32'h5555_5542);
        lanes = 4'hF;
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_PAYLOAD, 32'h0000_FF42);
    endtask
    task automatic t_send;
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_CAP_HDR, 32'h0001_0000);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_LOW, 32'h1234_567B);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_HIGH, 32'h0);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_PAYLOAD, 32'hABCD_1234);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_EVT_EN, 32'h3);
        send(4'h0);
        chk("count", got_cnt, 8'h01);
        chk("narrow", {got_wide, got_addr[31:0]}, {1'b0, 32'h1234_5678});
        chk("payload", got_data, 32'h0000_1234);
        chk("irq sent", irq, 1'b1);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_EVT_STAT, 32'h1);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_EVT_CLR, 32'h1);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_ADDR_HIGH, 32'h0000_00A5);
        send(4'h3);
        chk("wide", {got_wide, got_addr}, {1'b1, 64'h0000_00A5_1234_5678});
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_EVT_CLR, 32'h1);
        @(posedge clk_sys);
        chk("irq clear", irq, 1'b0);
        wb(1'b1, INTERRUPT_MSG_CAP_HEADER_OFS_CAP_HDR, 32'h0);
        send(4'h0);
        chk("disabled", got_cnt, 8'h02);
        rd(INTERRUPT_MSG_CAP_HEADER_OFS_EVT_STAT, 32'h2);
        chk("irq drop", irq, 1'b1);
    endtask
    task automatic finish_test;
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        finish_test();
    end
    initial begin
        {rst_b, wb_cyc, wb_stb, wb_we, msg_req, wb_adr, wb_wdat, stall, wb_sel} = '0;
        errors = 0;
        n_compared = 0;
        lanes = 4'hF;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_ones();
        t_send();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        finish_test();
    end
endmodule
bind interrupt_msg_cap_header_regs interrupt_msg_cap_header_regs_props u_interrupt_msg_cap_header_regs_props (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .mwr_valid, .mwr_ready, .mwr_addr, .mwr_wide, .mwr_data, .mwr_upstream);
`default_nettype wire
